// *** inc/spz_uart_defs.vh ***
/*
 * Constants of the serial port: register indices, field positions,
 * reset values, mode codes and bit-timing counts.
 * Assumes it is included by bare name into every design file of the block.
 */
`ifndef SPZ_UART_DEFS_VH
`define SPZ_UART_DEFS_VH

// ****************************************************************
// Register indices (byte address = index * 4)
// ****************************************************************
`define SPZ_IDX_CTLST    8'h98
`define SPZ_IDX_DATA     8'h99
`define SPZ_IDX_CTRL     8'hC0
`define SPZ_IDX_IST      8'hC1
`define SPZ_IDX_IMSK     8'hC2
`define SPZ_IDX_BRL      8'hC3
`define SPZ_IDX_NONE     8'h00
`define SPZ_HI_ZERO      22'h00_0000

// ****************************************************************
// Field positions
// ****************************************************************
`define SPZ_SC_SM0       7
`define SPZ_SC_MODE1     6
`define SPZ_SC_FILT      5
`define SPZ_SC_REN       4
`define SPZ_SC_TXNINE    3
`define SPZ_SC_RXNINE    2
`define SPZ_SC_TXDONE    1
`define SPZ_SC_RXDONE    0
`define SPZ_CT_IEN       0
`define SPZ_CT_DBL       1
`define SPZ_CT_FESEL     2
`define SPZ_EV_TXDONE    0
`define SPZ_EV_RXDONE    1
`define SPZ_EV_FE        2

// ****************************************************************
// Reset values
// ****************************************************************
`define SPZ_RST_BYTE     8'h00
`define SPZ_RST_EV       3'h0
`define SPZ_RST_WORD     32'h0000_0000
`define SPZ_RST_CNT      4'h0
`define SPZ_RST_DIV      9'h000
`define SPZ_RST_SHIFT    11'h7FF

// ****************************************************************
// Modes
// ****************************************************************
`define SPZ_MODE0        2'b00
`define SPZ_MODE1        2'b01
`define SPZ_MODE2        2'b10

// ****************************************************************
// Timing: clocks per tick; 16 ticks per async bit, 2 per shift bit
// ****************************************************************
`define SPZ_M0_SLOW_HALF 9'h006
`define SPZ_M0_FAST_HALF 9'h002
`define SPZ_M2_SLOW_TICK 9'h004
`define SPZ_M2_FAST_TICK 9'h002
`define SPZ_DIV_ONE      9'h001
`define SPZ_TICK_LAST    4'hF
`define SPZ_TICK_MID     4'h7
`define SPZ_M0_LAST      4'h1
`define SPZ_BITS_M0      4'h8
`define SPZ_BITS_M1      4'hA
`define SPZ_BITS_M23     4'hB
`define SPZ_CNT_ONE      4'h1
`define SPZ_CNT_STOPBEG  4'h2
`define SPZ_RX_NINTH     4'h9
`define SPZ_RX_STOP_M1   4'h9
`define SPZ_RX_STOP_M23  4'hA

`endif

// *** design/spz_baud.v ***
/*
 * Tick generator: one-cycle tick whose period follows the serial mode.
 * Assumes a single clock domain and the block-wide clock enable.
 */
`timescale 1ns/10ps
`include "spz_uart_defs.vh"

module spz_baud (
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       ce,
  input  wire [1:0] mode,
  input  wire       fast,
  input  wire       dbl,
  input  wire [7:0] reload,
  output reg        tick_q
);

  reg  [8:0] cnt_q;
  reg  [8:0] period;

  // ****************************************************************
  // Period select
  // ****************************************************************
  always @* begin
    if (mode == `SPZ_MODE0) begin
      period = fast ? `SPZ_M0_FAST_HALF : `SPZ_M0_SLOW_HALF;
    end else if (mode == `SPZ_MODE2) begin
      period = dbl ? `SPZ_M2_FAST_TICK : `SPZ_M2_SLOW_TICK;
    end else begin
      period = {1'b0, reload} + `SPZ_DIV_ONE;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q  <= `SPZ_RST_DIV;
      tick_q <= 1'b0;
    end else if (ce) begin
      if (cnt_q + `SPZ_DIV_ONE >= period) begin
        cnt_q  <= `SPZ_RST_DIV;
        tick_q <= 1'b1;
      end else begin
        cnt_q  <= cnt_q + `SPZ_DIV_ONE;
        tick_q <= 1'b0;
      end
    end
  end

endmodule

// *** design/spz_sync.v ***
/*
 * Receive pin synchroniser with falling-edge detect.
 * Assumes the pin idles high.
 */
`timescale 1ns/10ps
`include "spz_uart_defs.vh"

module spz_sync (
  input  wire hclk,
  input  wire hresetn,
  input  wire ce,
  input  wire din,
  output wire line,
  output wire fall
);

  reg meta_q;
  reg sync_q;
  reg prev_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else if (ce) begin
      meta_q <= din;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign line = sync_q;
  assign fall = prev_q & ~sync_q;

endmodule

// *** design/spz_uart.v ***
/*
 * Serial port: four modes, multiprocessor filter, framing error,
 * split receive/transmit buffers, AHB-Lite register slave, interrupt.
 * Assumes one clock hclk, async active-low reset, single-word transfers.
 */
// Contract
// - Top control bit: mode bit or framing flag
// - Bad stop sets framing flag until cleared (code sets it only while fesel_q is set)
// - Two mode bits pick frame and rate
// - Filter on: no receive flag if ninth zero
// - Mode 1 filter: receive flag needs stop
// - Mode 0 filter bit picks shift clock
// - Receive only while receive enable set
// - Modes 2/3 send software ninth bit
// - Capture ninth bit or stop bit
// - Transmit flag timing; software clears it
// - Receive flag timing; software clears it
// - Data address: read receive, write transmit
// - Drive transmit pin, read receive pin
// - Interrupt enable gates both done flags
`timescale 1ns/10ps
`include "spz_uart_defs.vh"

module spz_uart (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        ce,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata_q,
  output reg         hreadyout_q,
  output reg         hresp_q,
  output reg         txd_q,
  input  wire        rxd_in,
  output reg         rxd_out_q,
  output reg         rxd_oe_q,
  output reg         irq_q
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg        sm0_q, mode1_q, filt_q, ren_q, tx_nine_q, rx_nine_q, tx_done_q, rx_done_q, fe_q;
  reg        fesel_q, dbl_q, ien_q;
  reg  [7:0] brl_q;
  reg  [7:0] rx_buf_q;
  reg  [2:0] ist_q;
  reg  [2:0] imsk_q;
  reg  [2:0] ev_q;
  reg        wr_q;
  reg        rdp_q;
  reg  [7:0] aidx_q;
  reg  [7:0] rd_mux;
  reg        tx_busy_q, m0rx_q;
  reg  [10:0] tx_sh_q;
  reg  [3:0] tx_cnt_q, tx_sub_q;
  reg        rx_busy_q, rx_b9_q;
  reg  [7:0] rx_sh_q;
  reg  [3:0] rx_cnt_q, rx_sub_q;

  wire [1:0] mode    = {sm0_q, mode1_q};
  wire       m0      = (mode == `SPZ_MODE0);
  wire       m1      = (mode == `SPZ_MODE1);
  wire       tick;
  wire       rx_line;
  wire       rx_fall;
  wire [7:0] wd      = hwdata[7:0];
  wire       take    = hsel & hready & htrans[1];
  wire       idx_ok  = (haddr[31:10] == `SPZ_HI_ZERO) & (haddr[1:0] == 2'b00);
  wire       we_csr  = wr_q & (aidx_q == `SPZ_IDX_CTLST);
  wire       we_buf  = wr_q & (aidx_q == `SPZ_IDX_DATA);
  wire       we_ctrl = wr_q & (aidx_q == `SPZ_IDX_CTRL);
  wire       we_ist  = wr_q & (aidx_q == `SPZ_IDX_IST);
  wire       we_imsk = wr_q & (aidx_q == `SPZ_IDX_IMSK);
  wire       we_brl  = wr_q & (aidx_q == `SPZ_IDX_BRL);
  wire       tx_end  = m0 ? (tx_sub_q == `SPZ_M0_LAST) : (tx_sub_q == `SPZ_TICK_LAST);
  wire [3:0] rx_stop = m1 ? `SPZ_RX_STOP_M1 : `SPZ_RX_STOP_M23;
  wire       rx_nb   = m1 ? rx_line : rx_b9_q;

  spz_baud u_baud (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .mode    (mode),
    .fast    (filt_q),
    .dbl     (dbl_q),
    .reload  (brl_q),
    .tick_q  (tick)
  );

  spz_sync u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .din     (rxd_in),
    .line    (rx_line),
    .fall    (rx_fall)
  );

  // ****************************************************************
  // Read mux
  // ****************************************************************
  always @* begin
    if (aidx_q == `SPZ_IDX_CTLST) begin
      rd_mux = {fesel_q ? fe_q : sm0_q, mode1_q, filt_q, ren_q,
                tx_nine_q, rx_nine_q, tx_done_q, rx_done_q};
    end else if (aidx_q == `SPZ_IDX_DATA) begin
      rd_mux = rx_buf_q;
    end else if (aidx_q == `SPZ_IDX_CTRL) begin
      rd_mux = {5'h00, fesel_q, dbl_q, ien_q};
    end else if (aidx_q == `SPZ_IDX_IST) begin
      rd_mux = {5'h00, ist_q};
    end else if (aidx_q == `SPZ_IDX_IMSK) begin
      rd_mux = {5'h00, imsk_q};
    end else if (aidx_q == `SPZ_IDX_BRL) begin
      rd_mux = brl_q;
    end else begin
      rd_mux = `SPZ_RST_BYTE;
    end
  end

  // ****************************************************************
  // Bus slave and software registers
  // ****************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q        <= 1'b0;
      rdp_q       <= 1'b0;
      aidx_q      <= `SPZ_IDX_NONE;
      hrdata_q    <= `SPZ_RST_WORD;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      sm0_q       <= 1'b0;
      mode1_q     <= 1'b0;
      filt_q      <= 1'b0;
      ren_q       <= 1'b0;
      tx_nine_q   <= 1'b0;
      fesel_q     <= 1'b0;
      dbl_q       <= 1'b0;
      ien_q       <= 1'b0;
      brl_q       <= `SPZ_RST_BYTE;
      imsk_q      <= `SPZ_RST_EV;
      ist_q       <= `SPZ_RST_EV;
      irq_q       <= 1'b0;
    end else if (ce) begin
      wr_q <= take & hwrite;
      if (take) begin
        aidx_q <= idx_ok ? haddr[9:2] : `SPZ_IDX_NONE;
      end
      // Reads take one wait state so data comes from a flop
      if (take & ~hwrite) begin
        rdp_q       <= 1'b1;
        hreadyout_q <= 1'b0;
      end else if (rdp_q) begin
        rdp_q       <= 1'b0;
        hreadyout_q <= 1'b1;
        hrdata_q    <= {24'h00_0000, rd_mux};
      end
      if (we_csr) begin
        if (!fesel_q) begin
          sm0_q <= wd[`SPZ_SC_SM0];
        end
        mode1_q   <= wd[`SPZ_SC_MODE1];
        filt_q    <= wd[`SPZ_SC_FILT];
        ren_q     <= wd[`SPZ_SC_REN];
        tx_nine_q <= wd[`SPZ_SC_TXNINE];
      end
      if (we_ctrl) begin
        ien_q   <= wd[`SPZ_CT_IEN];
        dbl_q   <= wd[`SPZ_CT_DBL];
        fesel_q <= wd[`SPZ_CT_FESEL];
      end
      if (we_imsk) begin
        imsk_q <= wd[2:0];
      end
      if (we_brl) begin
        brl_q <= wd;
      end
      // Sticky events: a new event wins over the write-one clear
      ist_q <= (ist_q & ~(we_ist ? wd[2:0] : `SPZ_RST_EV)) | ev_q;
      irq_q <= (|(ist_q & imsk_q)) | (ien_q & (tx_done_q | rx_done_q));
    end
  end

  // ****************************************************************
  // Serial engine: flags, transmitter, receiver
  // ****************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_done_q <= 1'b0;
      rx_done_q <= 1'b0;
      fe_q      <= 1'b0;
      rx_nine_q <= 1'b0;
      ev_q      <= `SPZ_RST_EV;
      rx_buf_q  <= `SPZ_RST_BYTE;
      tx_busy_q <= 1'b0;
      m0rx_q    <= 1'b0;
      tx_sh_q   <= `SPZ_RST_SHIFT;
      tx_cnt_q  <= `SPZ_RST_CNT;
      tx_sub_q  <= `SPZ_RST_CNT;
      txd_q     <= 1'b1;
      rxd_out_q <= 1'b1;
      rxd_oe_q  <= 1'b0;
      rx_busy_q <= 1'b0;
      rx_b9_q   <= 1'b0;
      rx_sh_q   <= `SPZ_RST_BYTE;
      rx_cnt_q  <= `SPZ_RST_CNT;
      rx_sub_q  <= `SPZ_RST_CNT;
    end else if (ce) begin
      ev_q <= `SPZ_RST_EV;
      // Software writes come first so hardware sets below win
      if (we_csr) begin
        tx_done_q <= wd[`SPZ_SC_TXDONE];
        rx_done_q <= wd[`SPZ_SC_RXDONE];
        rx_nine_q <= wd[`SPZ_SC_RXNINE];
        if (fesel_q) begin
          fe_q <= wd[`SPZ_SC_SM0];
        end
      end
      // Transmit start, or mode 0 receive start
      if (we_buf) begin
        tx_busy_q <= 1'b1;
        m0rx_q    <= 1'b0;
        tx_sub_q  <= `SPZ_RST_CNT;
        txd_q     <= 1'b0;
        if (m0) begin
          tx_sh_q   <= {3'b111, wd};
          tx_cnt_q  <= `SPZ_BITS_M0;
          rxd_out_q <= wd[0];
          rxd_oe_q  <= 1'b1;
        end else begin
          tx_sh_q  <= {1'b1, m1 ? 1'b1 : tx_nine_q, wd, 1'b0};
          tx_cnt_q <= m1 ? `SPZ_BITS_M1 : `SPZ_BITS_M23;
        end
      end else if (m0 & ren_q & ~rx_done_q & ~tx_busy_q) begin
        tx_busy_q <= 1'b1;
        m0rx_q    <= 1'b1;
        tx_sub_q  <= `SPZ_RST_CNT;
        tx_cnt_q  <= `SPZ_BITS_M0;
        txd_q     <= 1'b0;
        rxd_oe_q  <= 1'b0;
      end else if (tx_busy_q & tick) begin
        if (!tx_end) begin
          tx_sub_q <= tx_sub_q + `SPZ_CNT_ONE;
          if (m0) begin
            txd_q <= 1'b1;
            if (m0rx_q) begin
              rx_sh_q <= {rx_line, rx_sh_q[7:1]};
            end
          end
        end else begin
          tx_sub_q <= `SPZ_RST_CNT;
          if (tx_cnt_q == `SPZ_CNT_ONE) begin
            tx_busy_q <= 1'b0;
            m0rx_q    <= 1'b0;
            txd_q     <= 1'b1;
            rxd_oe_q  <= 1'b0;
            if (m0rx_q) begin
              rx_done_q            <= 1'b1;
              rx_buf_q             <= rx_sh_q;
              ev_q[`SPZ_EV_RXDONE] <= 1'b1;
            end else if (m0) begin
              tx_done_q            <= 1'b1;
              ev_q[`SPZ_EV_TXDONE] <= 1'b1;
            end
          end else begin
            tx_cnt_q <= tx_cnt_q - `SPZ_CNT_ONE;
            tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
            if (m0) begin
              rxd_out_q <= tx_sh_q[1];
              txd_q     <= 1'b0;
            end else begin
              txd_q <= tx_sh_q[1];
              if (tx_cnt_q == `SPZ_CNT_STOPBEG) begin
                tx_done_q            <= 1'b1;
                ev_q[`SPZ_EV_TXDONE] <= 1'b1;
              end
            end
          end
        end
      end
      // Asynchronous receiver
      if (~ren_q | m0) begin
        rx_busy_q <= 1'b0;
      end else if (!rx_busy_q) begin
        if (rx_fall) begin
          rx_busy_q <= 1'b1;
          rx_sub_q  <= `SPZ_RST_CNT;
          rx_cnt_q  <= `SPZ_RST_CNT;
        end
      end else if (tick) begin
        rx_sub_q <= rx_sub_q + `SPZ_CNT_ONE;
        if (rx_sub_q == `SPZ_TICK_MID) begin
          rx_cnt_q <= rx_cnt_q + `SPZ_CNT_ONE;
          if (rx_cnt_q == `SPZ_RST_CNT) begin
            if (rx_line) begin
              rx_busy_q <= 1'b0;
            end
          end else if (rx_cnt_q == rx_stop) begin
            rx_busy_q <= 1'b0;
            if (~rx_line & fesel_q) begin
              fe_q             <= 1'b1;
              ev_q[`SPZ_EV_FE] <= 1'b1;
            end
            if (~rx_done_q & (~filt_q | rx_nb)) begin
              rx_done_q            <= 1'b1;
              rx_buf_q             <= rx_sh_q;
              rx_nine_q            <= rx_nb;
              ev_q[`SPZ_EV_RXDONE] <= 1'b1;
            end
          end else if (rx_cnt_q == `SPZ_RX_NINTH) begin
            rx_b9_q <= rx_line;
          end else begin
            rx_sh_q <= {rx_line, rx_sh_q[7:1]};
          end
        end
      end
    end
  end

endmodule

// *** verification/spz_uart_properties.sv ***
/* Checker for the serial port bus slave and pins.
   Assumes binding to spz_uart with ce held high by the bench. */
`timescale 1ns/10ps
`include "spz_uart_defs.vh"
module spz_uart_properties (
  input wire        hclk,
  input wire        hresetn,
  input wire        ce,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [2:0]  hsize,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata_q,
  input wire        hreadyout_q,
  input wire        hresp_q,
  input wire        txd_q,
  input wire        rxd_in,
  input wire        rxd_out_q,
  input wire        rxd_oe_q,
  input wire        irq_q
);
  // ****************
  // Write age
  // ****************
  logic       wr_dp_q;
  logic [3:0] wr_age_q;
  wire        take = hsel & hready & htrans[1] & ce;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp_q  <= 1'b0;
      wr_age_q <= 4'hF;
    end else begin
      wr_dp_q  <= take & hwrite;
      wr_age_q <= wr_dp_q ? 4'h0 : ((wr_age_q == 4'hF) ? 4'hF : wr_age_q + 4'h1);
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****************
  // Properties
  // ****************
  AST_RESP_OKAY: assert property (hresp_q == 1'b0)
    else $error("bus response not okay");
  AST_READ_WAIT: assert property (take & !hwrite |=> !hreadyout_q ##1 hreadyout_q)
    else $error("read wait state wrong");
  AST_WRITE_NOWAIT: assert property (take & hwrite |=> hreadyout_q)
    else $error("write data phase stalled");
  AST_READY_ONE: assert property (!hreadyout_q |=> hreadyout_q)
    else $error("ready low too long");
  AST_RDATA_HIGH: assert property (hrdata_q[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  AST_RDATA_HOLD: assert property ($changed(hrdata_q) |-> $rose(hreadyout_q))
    else $error("read data moved outside a read");
  AST_TXD_IDLE: assert property ($rose(hresetn) |-> txd_q && !rxd_oe_q)
    else $error("pins not idle after reset");
  AST_TX_START: assert property (take & hwrite & (haddr[9:2] == `SPZ_IDX_DATA)
    |-> ##[1:20] !txd_q)
    else $error("buffer write started no frame");
  AST_IRQ_FALL: assert property ($fell(irq_q) |-> wr_age_q <= 4'h3)
    else $error("interrupt dropped without a write");
endmodule

bind spz_uart spz_uart_properties chk (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata_q(hrdata_q), .hreadyout_q(hreadyout_q), .hresp_q(hresp_q),
  .txd_q(txd_q), .rxd_in(rxd_in), .rxd_out_q(rxd_out_q), .rxd_oe_q(rxd_oe_q), .irq_q(irq_q));

// *** verification/spz_peer.sv ***
/* Far-side serial device: sends frames on the receive line, captures
   frames from the transmit pin. Assumes the bench sets nbits; bpc keeps its default of 16. */
`timescale 1ns/10ps
module spz_peer (
  input  wire hclk,
  input  wire txd,
  output reg  line
);
  int          bpc    = 16;
  int          nbits  = 10;
  bit          listen = 1'b0;
  logic [10:0] got;
  int          frames = 0;
  initial line = 1'b1;
  // ****************
  // Capture at bit centres
  // ****************
  always @(negedge txd) begin
    if (listen) begin
      repeat (bpc / 2) @(negedge hclk);
      for (int i = 0; i < nbits; i++) begin
        got[i] = txd;
        if (i < nbits - 1) repeat (bpc) @(negedge hclk);
      end
      frames++;
    end
  end
  // Frame bits LSB first, then driven back to the high idle level
  task send(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      line <= bits[i];
      repeat (bpc) @(posedge hclk);
    end
    line <= 1'b1;
  endtask
endmodule

// *** verification/spz_uart_tb_top.sv ***
/* Self-checking bench for the serial port.
   Assumes spz_uart, its checker and the far-side model are compiled. */
`timescale 1ns/10ps
`include "spz_uart_defs.vh"
module spz_uart_tb_top;
  logic        hclk, hresetn, hsel, hwrite;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, rv;
  wire  [31:0] hrdata;
  wire         rdy, resp, txd, rxd_out, rxd_oe, irq, peer_line;
  wire         rxd = rxd_oe ? rxd_out : peer_line;
  int          fail_count = 0;
  int          checks_done = 0;

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  spz_uart dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(rdy),
    .hrdata_q(hrdata), .hreadyout_q(rdy), .hresp_q(resp), .txd_q(txd), .rxd_in(rxd),
    .rxd_out_q(rxd_out), .rxd_oe_q(rxd_oe), .irq_q(irq));
  spz_peer peer (.hclk(hclk), .txd(txd), .line(peer_line));

  // ****************
  // Common tasks
  // ****************
  task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wait_rdy;
    int n;
    n = 0;
    @(negedge hclk);
    while (rdy !== 1'b1 && n < 100) begin
      @(negedge hclk);
      n++;
    end
    if (n >= 100) fail_count++;
    rv = hrdata;
    @(posedge hclk);
  endtask
  task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {22'h00_0000, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    wait_rdy;
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task rdc(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e, input string what);
    bus(1'b0, idx, 8'h00);
    chk(what, rv & {24'hFF_FFFF, m}, {24'h00_0000, e});
  endtask
  task irq_is(input logic e, input string what);
    repeat (3) @(negedge hclk);
    chk(what, irq, e);
  endtask
  task wait_frames(input int k);
    int n;
    n = 0;
    while (peer.frames < k && n < 5000) begin
      @(negedge hclk);
      n++;
    end
    if (peer.frames < k) fail_count++;
  endtask

  // ****************
  // Scenarios
  // ****************
  task t_regs;
    rdc(`SPZ_IDX_CTLST, 8'hFF, 8'h00, "csr_reset");
    rdc(`SPZ_IDX_DATA, 8'hFF, 8'h00, "buf_reset");
    wr(8'h10, 8'hFF);
    rdc(8'h10, 8'hFF, 8'h00, "unmapped");
    wr(`SPZ_IDX_BRL, 8'h00);
    wr(`SPZ_IDX_CTLST, 8'h50);
    rdc(`SPZ_IDX_CTLST, 8'hFF, 8'h50, "csr_rw");
  endtask
  task t_tx_m1;
    int n;
    peer.listen = 1'b1;
    wr(`SPZ_IDX_IMSK, 8'h01);
    wr(`SPZ_IDX_DATA, 8'hA5);
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(negedge hclk);
      n++;
    end
    chk("txdone_at_stop", (n > 136 && n < 152), 1'b1);
    wait_frames(1);
    chk("tx_frame", peer.got[9:0], {1'b1, 8'hA5, 1'b0});
    rdc(`SPZ_IDX_CTLST, 8'hFB, 8'h52, "txdone_set");
    wr(`SPZ_IDX_IMSK, 8'h00);
    irq_is(1'b0, "masked");
    wr(`SPZ_IDX_IMSK, 8'h01);
    irq_is(1'b1, "unmasked");
    wr(`SPZ_IDX_IST, 8'h01);
    irq_is(1'b0, "status_clear");
    wr(`SPZ_IDX_CTLST, 8'h50);
    rdc(`SPZ_IDX_CTLST, 8'hFB, 8'h50, "txdone_clear");
  endtask
  task t_rx_m1;
    wr(`SPZ_IDX_CTRL, 8'h01);
    peer.send({1'b1, 8'h3C, 1'b0}, 10);
    irq_is(1'b1, "rxdone_irq");
    rdc(`SPZ_IDX_CTLST, 8'hFF, 8'h55, "rxdone_stop_bit");
    rdc(`SPZ_IDX_DATA, 8'hFF, 8'h3C, "rx_data");
    wr(`SPZ_IDX_CTLST, 8'h50);
    irq_is(1'b0, "rxdone_clear");
  endtask
  task t_filter_m1;
    wr(`SPZ_IDX_CTRL, 8'h05);
    wr(`SPZ_IDX_CTLST, 8'h70);
    peer.send({1'b0, 8'h55, 1'b0}, 10);
    rdc(`SPZ_IDX_CTLST, 8'hFB, 8'hF0, "fe_no_rxdone");
    rdc(`SPZ_IDX_IST, 8'h04, 8'h04, "fe_event");
    wr(`SPZ_IDX_CTLST, 8'h70);
    rdc(`SPZ_IDX_CTLST, 8'h80, 8'h00, "fe_clear");
    peer.send({1'b1, 8'h66, 1'b0}, 10);
    rdc(`SPZ_IDX_CTLST, 8'hFB, 8'h71, "stop_ok_rxdone");
    wr(`SPZ_IDX_CTRL, 8'h01);
    wr(`SPZ_IDX_CTLST, 8'h40);
    peer.send({1'b1, 8'h99, 1'b0}, 10);
    rdc(`SPZ_IDX_CTLST, 8'hFB, 8'h40, "ren_off");
    rdc(`SPZ_IDX_DATA, 8'hFF, 8'h66, "buf_kept");
  endtask
  task t_m3;
    peer.nbits = 11;
    wr(`SPZ_IDX_CTLST, 8'hD8);
    wr(`SPZ_IDX_DATA, 8'h81);
    wait_frames(2);
    chk("ninth_tx", peer.got, {2'b11, 8'h81, 1'b0});
    wr(`SPZ_IDX_CTLST, 8'hF8);
    peer.send({2'b10, 8'h42, 1'b0}, 11);
    rdc(`SPZ_IDX_CTLST, 8'hFB, 8'hF8, "ninth_zero");
    peer.send({2'b11, 8'h24, 1'b0}, 11);
    rdc(`SPZ_IDX_CTLST, 8'hFF, 8'hFD, "ninth_one");
    rdc(`SPZ_IDX_DATA, 8'hFF, 8'h24, "rx9_data");
  endtask
  task t_m0(input logic sm2, input int per);
    int         n;
    logic [7:0] b;
    peer.listen = 1'b0;
    wr(`SPZ_IDX_CTLST, {2'b00, sm2, 5'b00000});
    wr(`SPZ_IDX_DATA, 8'h96);
    for (int i = 0; i < 8; i++) begin
      n = 0;
      while (txd !== 1'b0 && n < 200) begin
        @(negedge hclk);
        n++;
      end
      while (txd !== 1'b1 && n < 200) begin
        @(negedge hclk);
        n++;
      end
      b[i] = rxd;
      if (i == 4) begin
        chk("m0_period", n, per);
        chk("m0_drive", rxd_oe, 1'b1);
      end
    end
    repeat (per) @(negedge hclk);
    chk("m0_data", b, 8'h96);
    rdc(`SPZ_IDX_CTLST, 8'hFF, {2'b00, sm2, 5'b00010}, "m0_txdone");
  endtask
  task t_m0_rx;
    peer.line <= 1'b0;
    wr(`SPZ_IDX_CTLST, 8'h10);
    repeat (150) @(negedge hclk);
    rdc(`SPZ_IDX_CTLST, 8'hFF, 8'h11, "m0_rx_flag");
    rdc(`SPZ_IDX_DATA, 8'hFF, 8'h00, "m0_rx_data");
    wr(`SPZ_IDX_CTLST, 8'h00);
    peer.line <= 1'b1;
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    tally_and_finish;
  end

  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    hwrite  = 1'b0;
    htrans  = 2'b00;
    haddr   = 32'h0000_0000;
    hwdata  = 32'h0000_0000;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_tx_m1;
    t_rx_m1;
    t_filter_m1;
    t_m3;
    t_m0(1'b0, 12);
    t_m0(1'b1, 4);
    t_m0_rx;
    tally_and_finish;
  end
endmodule
